// ===== verilog/hcj_channel_b.sv
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - Three-bit result at bits six-four, resets zero
// - Clean finish loads code zero
// - STALL handshake loads code one
// - Too much data loads overrun code
// - Over/underrun with CRC/stuff error means retry
// - Short-enough packet with bad toggle: toggle mismatch
// - Short packet before total loads underrun
// - Timeout after token or data means retry
// - CRC, stuff, PID failures mean retry
// - Split ERR or three NYETs mean retry
// - Toggle mismatch means retry
// - Bit seven joins FIFO to disk path
// - Bit six exposes FIFO flags to shared status
// - Bits three/two join second/first DMA
// - Bit one feeds processor reads from FIFO
// - Bit zero sends processor writes to FIFO
// - DMA remaining shows fill or free space
// - Only highest of four attach bits kept
module hcj_channel_b
  import hcj_pkg::*;
#(
  parameter int CNT_W = 16                       // FIFO count width
) (
  input  wire logic             clk_i,           // System clock
  input  wire logic             rst_i,           // Synchronous reset
  // Wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [11:0]      wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // Transaction engine report
  input  wire hcj_end_t         end_i,
  // FIFO state and path directions
  input  wire logic [CNT_W-1:0] fifo_fill_i,     // Bytes held
  input  wire logic [CNT_W-1:0] fifo_free_i,     // Free space
  input  wire logic             fifo_full_i,
  input  wire logic             fifo_empty_i,
  input  wire hcj_flow_t        flow_i,
  // Path joins
  output logic                  disk_join_o,
  output logic                  disk_dir_o,
  output logic                  dma0_join_o,
  output logic                  dma1_join_o,
  output logic                  cpu_rd_join_o,
  output logic                  cpu_wr_join_o,
  output logic [CNT_W-1:0]      dma0_remain_o,
  output logic [CNT_W-1:0]      dma1_remain_o,
  output logic [CNT_W-1:0]      cpu_rd_remain_o,
  output logic [CNT_W-1:0]      cpu_wr_remain_o,
  // Shared FIFO status view
  output logic                  stat_full_o,
  output logic                  stat_empty_o,
  output logic                  stat_not_empty_o
);

  logic [2:0] result;        // Last transfer result code
  logic [7:0] attach;        // Port attach register
  logic [1:0] nyet_run;      // Consecutive NYET count

  // Bus decode
  wire bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire hit_res   = wb_adr_i == ADDR_RESULT;
  wire hit_att   = wb_adr_i == ADDR_ATTACH;
  wire hit_rem   = wb_adr_i == ADDR_REMAIN;
  wire hit_flg   = wb_adr_i == ADDR_FLAGS;
  wire att_write = bus_req & wb_we_i & hit_att & wb_sel_i[0];

  // Keep only the highest of the four exclusive bits
  function automatic logic [3:0] pick_high(input logic [3:0] v);
    logic [3:0] r;
    r = 4'h0;
    if (v[3]) begin
      r = 4'h8;
    end else if (v[2]) begin
      r = 4'h4;
    end else if (v[1]) begin
      r = 4'h2;
    end else if (v[0]) begin
      r = 4'h1;
    end
    return r;
  endfunction

  wire [7:0] wr_masked = wb_dat_i[7:0] & ATTACH_WMASK;
  wire [7:0] next_attach = {wr_masked[7:4], pick_high(wr_masked[3:0])};

  // Result classification, most specific first
  wire wire_err   = end_i.crc_err | end_i.stuff_err;
  wire nyet_full  = nyet_run == 2'(NYET_LIMIT - 1);  // Two NYETs already seen
  wire nyet_third = end_i.split_nyet & nyet_full;
  wire over_any   = end_i.over_pkt | end_i.over_total;
  wire tog_only   = end_i.toggle_bad & ~end_i.over_pkt;
  wire retry_hit  = end_i.timeout | wire_err | end_i.pid_check | end_i.pid_bad
                  | end_i.split_err | nyet_third | tog_only;
  logic [2:0] next_result;
  always_comb begin
    if (retry_hit) begin
      next_result = RES_RETRY;
    end else if (end_i.stall) begin
      next_result = RES_STALL;
    end else if (over_any) begin
      next_result = RES_OVERRUN;
    end else if (end_i.short_pkt) begin
      next_result = RES_UNDERRUN;
    end else begin
      next_result = RES_OK;
    end
  end

  // Read data mux
  wire [31:0] rd_res = {24'h00_0000, 1'b0, result, 4'h0};
  wire [31:0] rd_att = {24'h00_0000, attach};
  wire [31:0] rd_rem = {{(32 - CNT_W){1'b0}}, fifo_fill_i};
  wire [31:0] rd_flg = {26'h000_0000, flow_i.disk, flow_i.dma1, flow_i.dma0,
                        fifo_full_i, fifo_empty_i, ~fifo_empty_i};
  wire [31:0] next_dat = hit_res ? rd_res : hit_att ? rd_att : hit_rem ? rd_rem : hit_flg ? rd_flg : 32'h0000_0000;

  // Bus acknowledge: one cycle after request, any address answered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= next_dat;
    end
  end

  // Attach register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      attach <= RESET_BYTE;
    end else if (att_write) begin
      attach <= next_attach;
    end
  end

  // Result code and NYET run
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result   <= RES_OK;
      nyet_run <= 2'h0;
    end else begin
      if (end_i.done) begin
        result <= next_result;
      end
      if (end_i.done) begin
        nyet_run <= 2'h0;
      end else if (end_i.split_nyet && !nyet_full) begin
        nyet_run <= nyet_run + 2'h1;
      end else if (end_i.split_err) begin
        nyet_run <= 2'h0;
      end
    end
  end

  // Path outputs, registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      disk_join_o      <= 1'b0;
      disk_dir_o       <= 1'b0;
      dma0_join_o      <= 1'b0;
      dma1_join_o      <= 1'b0;
      cpu_rd_join_o    <= 1'b0;
      cpu_wr_join_o    <= 1'b0;
      dma0_remain_o    <= '0;
      dma1_remain_o    <= '0;
      cpu_rd_remain_o  <= '0;
      cpu_wr_remain_o  <= '0;
      stat_full_o      <= 1'b0;
      stat_empty_o     <= 1'b0;
      stat_not_empty_o <= 1'b0;
    end else begin
      disk_join_o      <= attach[ATT_DISK];
      disk_dir_o       <= attach[ATT_DISK] & flow_i.disk;
      dma1_join_o      <= attach[ATT_DMA1];
      dma0_join_o      <= attach[ATT_DMA0];
      cpu_rd_join_o    <= attach[ATT_CPU_RD];
      cpu_wr_join_o    <= attach[ATT_CPU_WR];
      dma0_remain_o    <= !attach[ATT_DMA0] ? '0 : flow_i.dma0 ? fifo_fill_i : fifo_free_i;
      dma1_remain_o    <= !attach[ATT_DMA1] ? '0 : flow_i.dma1 ? fifo_fill_i : fifo_free_i;
      cpu_rd_remain_o  <= attach[ATT_CPU_RD] ? fifo_fill_i : '0;
      cpu_wr_remain_o  <= attach[ATT_CPU_WR] ? fifo_free_i : '0;
      stat_full_o      <= attach[ATT_STAT] & fifo_full_i;
      stat_empty_o     <= attach[ATT_STAT] & fifo_empty_i;
      stat_not_empty_o <= attach[ATT_STAT] & ~fifo_empty_i;
    end
  end

  // Checks
  property p_reserved_zero;
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o && $past(hit_res) |-> wb_dat_o[7] == 1'b0 && wb_dat_o[3:0] == 4'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved result bits set");

  property p_stall;
    @(posedge clk_i) disable iff (rst_i)
    end_i.done && end_i.stall && !retry_hit |=> result == RES_STALL;
  endproperty
  a_stall: assert property (p_stall) else $error("Stall code wrong");

  property p_ok;
    @(posedge clk_i) disable iff (rst_i)
    end_i.done && !retry_hit && !end_i.stall && !over_any && !end_i.short_pkt |=> result == RES_OK;
  endproperty
  a_ok: assert property (p_ok) else $error("Clean code wrong");

  property p_retry;
    @(posedge clk_i) disable iff (rst_i)
    end_i.done && (end_i.timeout || wire_err) |=> result == RES_RETRY;
  endproperty
  a_retry: assert property (p_retry) else $error("Retry code wrong");

  property p_overrun;
    @(posedge clk_i) disable iff (rst_i)
    end_i.done && over_any && !retry_hit && !end_i.stall |=> result == RES_OVERRUN;
  endproperty
  a_overrun: assert property (p_overrun) else $error("Overrun code wrong");

  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
    !end_i.done |=> $stable(result);
  endproperty
  a_hold: assert property (p_hold) else $error("Result changed without end");

  property p_onehot;
    @(posedge clk_i) disable iff (rst_i)
    $onehot0(attach[3:0]);
  endproperty
  a_onehot: assert property (p_onehot) else $error("Several attach bits set");

  property p_dma0_remain;
    @(posedge clk_i) disable iff (rst_i)
    attach[ATT_DMA0] && flow_i.dma0 |=> dma0_remain_o == $past(fifo_fill_i);
  endproperty
  a_dma0_remain: assert property (p_dma0_remain) else $error("DMA remain wrong");

  property p_stat;
    @(posedge clk_i) disable iff (rst_i)
    !attach[ATT_STAT] |=> !stat_full_o && !stat_empty_o && !stat_not_empty_o;
  endproperty
  a_stat: assert property (p_stat) else $error("Status shown while detached");

  // Bus handshake: each request gets a single one-cycle acknowledge
  sequence s_bus_take;
    bus_req;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
    s_bus_take |=> s_ack_pulse;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("Acknowledge not a single pulse");

  property p_ack_cause;
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> $past(bus_req);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("Acknowledge without request");

  property p_attach_write;
    @(posedge clk_i) disable iff (rst_i)
    att_write |=> attach == $past(next_attach);
  endproperty
  a_attach_write: assert property (p_attach_write) else $error("Attach write lost");

  property p_attach_keep;
    @(posedge clk_i) disable iff (rst_i)
    !att_write |=> $stable(attach);
  endproperty
  a_attach_keep: assert property (p_attach_keep) else $error("Attach changed without write");

  property p_attach_reserved;
    @(posedge clk_i) disable iff (rst_i)
    attach[5:4] == 2'h0;
  endproperty
  a_attach_reserved: assert property (p_attach_reserved) else $error("Reserved attach bits set");

  property p_underrun;
    @(posedge clk_i) disable iff (rst_i)
    end_i.done && end_i.short_pkt && !retry_hit && !end_i.stall && !over_any |=> result == RES_UNDERRUN;
  endproperty
  a_underrun: assert property (p_underrun) else $error("Underrun code wrong");

  property p_toggle_retry;
    @(posedge clk_i) disable iff (rst_i)
    end_i.done && end_i.toggle_bad && !end_i.over_pkt |=> result == RES_RETRY;
  endproperty
  a_toggle_retry: assert property (p_toggle_retry) else $error("Toggle mismatch code wrong");

  property p_toggle_over;
    @(posedge clk_i) disable iff (rst_i)
    end_i.done && end_i.toggle_bad && end_i.over_pkt && !retry_hit && !end_i.stall |=> result == RES_OVERRUN;
  endproperty
  a_toggle_over: assert property (p_toggle_over) else $error("Long packet toggle code wrong");

  property p_pid_retry;
    @(posedge clk_i) disable iff (rst_i)
    end_i.done && (end_i.pid_check || end_i.pid_bad) |=> result == RES_RETRY;
  endproperty
  a_pid_retry: assert property (p_pid_retry) else $error("PID fault code wrong");

  property p_split_retry;
    @(posedge clk_i) disable iff (rst_i)
    end_i.done && (end_i.split_err || nyet_third) |=> result == RES_RETRY;
  endproperty
  a_split_retry: assert property (p_split_retry) else $error("Split fault code wrong");

  property p_wire_over;
    @(posedge clk_i) disable iff (rst_i)
    end_i.done && wire_err && (over_any || end_i.short_pkt) |=> result == RES_RETRY;
  endproperty
  a_wire_over: assert property (p_wire_over) else $error("Length fault with line error");

  property p_timeout_retry;
    @(posedge clk_i) disable iff (rst_i)
    end_i.done && end_i.timeout |=> result == RES_RETRY;
  endproperty
  a_timeout_retry: assert property (p_timeout_retry) else $error("Timeout code wrong");

  property p_nyet_count;
    @(posedge clk_i) disable iff (rst_i)
    end_i.split_nyet && !end_i.done && !nyet_full |=> nyet_run == $past(nyet_run) + 2'h1;
  endproperty
  a_nyet_count: assert property (p_nyet_count) else $error("NYET run not counted");

  property p_result_range;
    @(posedge clk_i) disable iff (rst_i)
    result <= RES_RETRY;
  endproperty
  a_result_range: assert property (p_result_range) else $error("Reserved result code");

  property p_disk_join;
    @(posedge clk_i) disable iff (rst_i)
    !rst_i |=> disk_join_o == $past(attach[ATT_DISK]);
  endproperty
  a_disk_join: assert property (p_disk_join) else $error("Disk join wrong");

  property p_disk_dir;
    @(posedge clk_i) disable iff (rst_i)
    !rst_i |=> disk_dir_o == ($past(attach[ATT_DISK]) && $past(flow_i.disk));
  endproperty
  a_disk_dir: assert property (p_disk_dir) else $error("Disk direction wrong");

  property p_dma_join;
    @(posedge clk_i) disable iff (rst_i)
    !rst_i |=> dma1_join_o == $past(attach[ATT_DMA1]) && dma0_join_o == $past(attach[ATT_DMA0]);
  endproperty
  a_dma_join: assert property (p_dma_join) else $error("DMA join wrong");

  property p_cpu_rd;
    @(posedge clk_i) disable iff (rst_i)
    !rst_i |=> cpu_rd_join_o == $past(attach[ATT_CPU_RD]);
  endproperty
  a_cpu_rd: assert property (p_cpu_rd) else $error("Processor read join wrong");

  property p_cpu_wr;
    @(posedge clk_i) disable iff (rst_i)
    !rst_i |=> cpu_wr_join_o == $past(attach[ATT_CPU_WR]);
  endproperty
  a_cpu_wr: assert property (p_cpu_wr) else $error("Processor write join wrong");

  property p_dma1_remain;
    @(posedge clk_i) disable iff (rst_i)
    attach[ATT_DMA1] && !flow_i.dma1 |=> dma1_remain_o == $past(fifo_free_i);
  endproperty
  a_dma1_remain: assert property (p_dma1_remain) else $error("DMA free space wrong");

  property p_stat_view;
    @(posedge clk_i) disable iff (rst_i)
    attach[ATT_STAT] |=> stat_full_o == $past(fifo_full_i) && stat_not_empty_o == !$past(fifo_empty_i);
  endproperty
  a_stat_view: assert property (p_stat_view) else $error("Status view wrong");

endmodule

// ===== inc/hcj_pkg.sv
package hcj_pkg;
  // Register byte addresses (index times four)
  localparam int unsigned RESULT_IDX     = 32'h0000_014e;
  localparam int unsigned ATTACH_IDX     = 32'h0000_014f;
  localparam logic [11:0] ADDR_RESULT    = 12'(RESULT_IDX * 4);
  localparam logic [11:0] ADDR_ATTACH    = 12'(ATTACH_IDX * 4);
  localparam logic [11:0] ADDR_REMAIN    = 12'h0_600;  // Chosen: FIFO fill count view
  localparam logic [11:0] ADDR_FLAGS     = 12'h0_604;  // Chosen: flag and flow sense view
  // Field positions
  localparam int RES_LSB    = 4;
  localparam int ATT_DISK   = 7;
  localparam int ATT_STAT   = 6;
  localparam int ATT_DMA1   = 3;
  localparam int ATT_DMA0   = 2;
  localparam int ATT_CPU_RD = 1;
  localparam int ATT_CPU_WR = 0;
  localparam logic [7:0] ATTACH_WMASK = 8'hcf;
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam int NYET_LIMIT = 3;
  // Result codes
  localparam logic [2:0] RES_OK      = 3'h0;
  localparam logic [2:0] RES_STALL   = 3'h1;
  localparam logic [2:0] RES_OVERRUN = 3'h2;
  localparam logic [2:0] RES_UNDERRUN= 3'h3;
  localparam logic [2:0] RES_RETRY   = 3'h4;
  // Transfer end report from the transaction engine
  typedef struct packed {
    logic done;        // Transfer finished this cycle
    logic stall;       // STALL handshake
    logic timeout;     // No data or handshake in time
    logic crc_err;     // CRC error on data
    logic stuff_err;   // Bit stuffing error
    logic pid_check;   // PID check bits failed
    logic pid_bad;     // Invalid or undefined PID
    logic toggle_bad;  // Unexpected data toggle
    logic split_err;   // ERR in split interrupt
    logic split_nyet;  // NYET in split interrupt
    logic over_pkt;    // Longer than max packet length
    logic over_total;  // Beyond total transfer length
    logic short_pkt;   // Short packet before total reached
  } hcj_end_t;
  // Flow sense bits of attached paths
  typedef struct packed {
    logic disk;
    logic dma0;
    logic dma1;
  } hcj_flow_t;
endpackage

// ===== test/hcj_ep_model.sv
`timescale 1ns/1ps
// Endpoint side: turns a requested outcome into an end report
module hcj_ep_model
  import hcj_pkg::*;
(
  input  wire logic     clk_i,   // System clock
  input  wire logic     rst_i,   // Synchronous reset
  input  wire logic     send_i,  // Launch one report
  input  wire hcj_end_t want_i,  // Outcome to report
  output hcj_end_t      end_o    // Report to the channel
);
  // Report follows the outcome each cycle send is high, then idles at zero
  always_ff @(posedge clk_i) begin
    if (rst_i || !send_i) begin
      end_o <= '0;
    end else begin
      end_o <= want_i;
    end
  end
endmodule

// ===== test/host_channel_result_and_port_join_tb_top.sv
`timescale 1ns/1ps
// Bench: result codes and path joins against a reference model
module host_channel_result_and_port_join_tb_top
  import hcj_pkg::*;
;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, send = 0;
  logic [11:0] adr = '0;
  logic [31:0] dat = '0, rdat, q;
  logic ack;
  logic [3:0] sel = 4'h1, lane = 4'h1;
  hcj_end_t want = '0, endr;
  logic [15:0] fill = '0, free = '0;
  hcj_flow_t flow = '0;
  logic full = 0, empty = 1;
  wire [8:0] jv;
  wire [63:0] rv;
  int n_fail = 0, n_tests = 0, cyc_n = 0, nyet = 0, i;
  integer seed = 85548;
  logic [7:0] ex, att;
  logic [12:0] tbl [0:20] = '{13'h1_000, 13'h1_800, 13'h1_004, 13'h1_002, 13'h1_001, 13'h1_400,
    13'h1_200, 13'h1_100, 13'h1_080, 13'h1_040, 13'h1_010, 13'h1_020, 13'h1_204, 13'h1_101,
    13'h1_024, 13'h0_008, 13'h0_008, 13'h1_008, 13'h0_800, 13'h1_000, 13'h1_804};
  always #5 clk_i = ~clk_i;
  hcj_ep_model i_ep (.clk_i(clk_i), .rst_i(rst_i), .send_i(send), .want_i(want), .end_o(endr));
  hcj_channel_b i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .end_i(endr),
    .fifo_fill_i(fill), .fifo_free_i(free), .fifo_full_i(full), .fifo_empty_i(empty), .flow_i(flow),
    .disk_join_o(jv[8]), .disk_dir_o(jv[7]), .dma1_join_o(jv[6]), .dma0_join_o(jv[5]),
    .cpu_rd_join_o(jv[4]), .cpu_wr_join_o(jv[3]), .stat_full_o(jv[2]), .stat_empty_o(jv[1]),
    .stat_not_empty_o(jv[0]), .dma0_remain_o(rv[63:48]), .dma1_remain_o(rv[47:32]),
    .cpu_rd_remain_o(rv[31:16]), .cpu_wr_remain_o(rv[15:0]));
  // Compare and count
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One classic Wishbone cycle, waits for ack
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    sel <= lane;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      close_out();
    end
    q = rdat;
    cyc <= 0; stb <= 0;
  endtask
  // One end report and the expected code for it
  task automatic evt(input logic [12:0] f);
    hcj_end_t e;
    logic [2:0] c;
    e = hcj_end_t'(f);
    @(posedge clk_i);
    send <= 1; want <= e;
    @(posedge clk_i);
    send <= 0;
    if (!e.done) begin
      if (e.split_nyet) nyet++;
      else if (e.split_err) nyet = 0;
      return;
    end
    if (e.timeout | e.crc_err | e.stuff_err | e.pid_check | e.pid_bad | e.split_err
        | (e.toggle_bad & !e.over_pkt) | (e.split_nyet && nyet >= 2)) c = 3'h4;
    else if (e.stall) c = 3'h1;
    else if (e.over_pkt | e.over_total) c = 3'h2;
    else if (e.short_pkt) c = 3'h3;
    else c = 3'h0;
    nyet = 0;
    ex = {1'b0, c, 4'h0};
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n >= 5000) begin
      n_fail++;
      close_out();
    end
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    ex = 8'h00;
    wb(0, ADDR_RESULT, 0); chk("result_rst", q, 0);
    wb(0, ADDR_ATTACH, 0); chk("attach_rst", q, 0);
    wb(0, 12'h7_fc, 0); chk("unmapped", q, 0);
    for (i = 0; i < 21; i++) begin
      evt(tbl[i]);
      wb(0, ADDR_RESULT, 0); chk("result", q, ex);
    end
    wb(1, ADDR_RESULT, 32'h0000_00ff);
    wb(0, ADDR_RESULT, 0); chk("result_ro", q, ex);
    // A write without byte lane zero must leave the attach register alone
    lane = 4'h0;
    wb(1, ADDR_ATTACH, 32'h0000_00ff);
    lane = 4'h1;
    wb(0, ADDR_ATTACH, 0); chk("attach_lane", q, 0);
    for (i = 0; i < 24; i++) begin
      d_rand();
      att = {dat[7:6], 2'b00, dat[3] ? 4'h8 : dat[2] ? 4'h4 : dat[1] ? 4'h2 : {3'b000, dat[0]}};
      wb(0, ADDR_ATTACH, 0); chk("attach", q, att);
      // Remaining counts are checked two cycles after the attach readback, before the bus views
      repeat (2) @(posedge clk_i);
      chk("joins", jv, {att[7], att[7] & flow.disk, att[3], att[2], att[1], att[0],
        att[6] & full, att[6] & empty, att[6] & !empty});
      chk("remain", rv, {att[2] ? (flow.dma0 ? fill : free) : 16'h0000,
        att[3] ? (flow.dma1 ? fill : free) : 16'h0000,
        att[1] ? fill : 16'h0000, att[0] ? free : 16'h0000});
      wb(0, ADDR_REMAIN, 0); chk("fill_view", q, fill);
      wb(0, ADDR_FLAGS, 0); chk("flag_view", q, {flow.disk, flow.dma1, flow.dma0, full, empty, !empty});
    end
    close_out();
  end
  // Random FIFO state and attach write
  task automatic d_rand();
    @(posedge clk_i);
    fill <= 16'($random(seed)); free <= 16'($random(seed)); flow <= 3'($random(seed));
    full <= 1'($random(seed)); empty <= 1'($random(seed));
    wb(1, ADDR_ATTACH, 32'($random(seed)) & 32'h0000_00ff);
  endtask
endmodule
